// ==== common/cdhp_map.svh ====
// register offsets, field positions, reset values and timing counts
// for the character display host port; definitions only
`ifndef CDHP_MAP_SVH
`define CDHP_MAP_SVH

// register offsets (byte addresses, one aligned word each)
`define CDHP_CTRL_OFS 8'h00
`define CDHP_STATUS_OFS 8'h04

// control register fields
`define CDHP_CTRL_BUS4_BIT 0
`define CDHP_CTRL_DUTY_LSB 1
`define CDHP_CTRL_DECR_BIT 3
`define CDHP_CTRL_RESET 4'h0

// status register fields
`define CDHP_ST_PTR_LSB 0
`define CDHP_ST_BUSY_BIT 7
`define CDHP_ST_GLYPH_BIT 8
`define CDHP_ST_INSTR_LSB 16
`define CDHP_ST_ROW_LSB 24

// storage sizes
`define CDHP_DISP_DEPTH 80
`define CDHP_GLYPH_DEPTH 64
`define CDHP_LINE_CHARS 40

// timing
`define CDHP_CLK_NS 4
`define CDHP_BUSY_NS 1000
`define CDHP_BUSY_CYC ((`CDHP_BUSY_NS + `CDHP_CLK_NS - 1) / `CDHP_CLK_NS)
`define CDHP_ROW_NS 1000
`define CDHP_ROW_CYC (`CDHP_ROW_NS / `CDHP_CLK_NS)

`endif

// ==== common/cdhp_pkg.sv ====
// types shared by the character display host port
// assumes cdhp_map.svh for the numeric constants
package cdhp_pkg;
    typedef logic [7:0] cdhp_byte_t;
    typedef enum logic [1:0] {
        CDHP_DUTY_8 = 2'h0,
        CDHP_DUTY_11 = 2'h1,
        CDHP_DUTY_16 = 2'h2
    } cdhp_duty_t;
endpackage : cdhp_pkg

// ==== src/cdhp_top.sv ====
// character display host port: parallel host port, 80-byte display ram,
// 64-byte glyph ram, busy timing and the common/segment scan framing
// assumes host pins synchronous to core_clk; config over AXI4-Lite
//
// Notes on behaviour
// R1 - reg_select low instruction, high data
// R2 - dir_select 0 writes, 1 reads
// R3 - host strobes each transfer after selects settle
// R4 - 8-bit or 4-bit host width selectable
// R5 - 4-bit mode uses only high nibble lines
// R6 - busy_line carries busy during reads
// R7 - 80-byte display ram, one code each
// R8 - 64-byte writable glyph ram
// R9 - duty 1/8, 1/11 or 1/16
// R10 - 16 commons and 40 segments driven
// R11 - unscanned commons carry non-selection level
// R12 - at 1/11 commons 12 to 16 unused
// R13 - status read: busy bit 7, pointer below
// R14 - no instruction accepted while busy
// R15 - ram_pointer steps after each ram access
// R16 - 4-bit bytes as two nibbles, high first
// R17 - sample on strobe fall, drive while high
`include "cdhp_map.svh"
`timescale 1ns/1ns
`default_nettype none

module cdhp_top
    import cdhp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_select,
    input wire logic dir_select,
    input wire logic xfer_strobe,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic [7:0] bus_data_oe,
    output logic [7:0] common_outputs_low,
    output logic [7:0] common_outputs_high,
    output logic [39:0] segment_output,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    function automatic logic [6:0] cdhp_disp_idx(input logic [6:0] addr, input logic two_line);
        // second line starts at 0x40 and packs behind the first 40 bytes
        if (two_line && addr[6]) begin
            cdhp_disp_idx = 7'(`CDHP_LINE_CHARS) + {1'b0, addr[5:0]};
        end else begin
            cdhp_disp_idx = addr;
        end
    endfunction : cdhp_disp_idx
    function automatic logic [4:0] cdhp_rows(input logic [1:0] duty);
        unique case (duty)
            CDHP_DUTY_8: cdhp_rows = 5'h08;
            CDHP_DUTY_11: cdhp_rows = 5'h0B;
            CDHP_DUTY_16: cdhp_rows = 5'h10;
            default: cdhp_rows = 5'h08;
        endcase
    endfunction : cdhp_rows
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // configuration
    logic [3:0] ctrl_reg;
    logic ctrl_wr;
    wire logic bus4 = ctrl_reg[`CDHP_CTRL_BUS4_BIT];
    wire logic [1:0] duty = ctrl_reg[`CDHP_CTRL_DUTY_LSB +: 2];
    wire logic decr = ctrl_reg[`CDHP_CTRL_DECR_BIT];
    wire logic two_line = (duty == CDHP_DUTY_16);
    wire logic [4:0] rows = cdhp_rows(duty);
    // host port state
    logic strobe_prev_reg;
    logic phase_low_reg;
    logic [3:0] nib_hold_reg;
    logic busy_reg;
    logic [8:0] busy_cnt_reg;
    logic [6:0] ram_ptr_reg;
    logic glyph_sel_reg;
    cdhp_byte_t instruction_reg;
    cdhp_byte_t data_out_reg;
    logic [7:0] data_oe_reg;
    cdhp_byte_t display_ram [`CDHP_DISP_DEPTH];
    cdhp_byte_t glyph_ram [`CDHP_GLYPH_DEPTH];

    wire logic strobe_fall = strobe_prev_reg & ~xfer_strobe; // R17 R3
    // 4-bit mode: a byte completes on the second (low) nibble
    wire logic byte_done = strobe_fall & (~bus4 | phase_low_reg); // R16 R4
    wire cdhp_byte_t wr_byte = bus4 ? {nib_hold_reg, bus_data_in[7:4]} : bus_data_in; // R5
    wire logic wr_ok = byte_done & ~dir_select & ~busy_reg; // R2 R14
    wire logic instr_wr = wr_ok & ~reg_select; // R1
    wire logic data_wr = wr_ok & reg_select; // R1
    wire logic data_rd = byte_done & dir_select & reg_select;
    wire logic [6:0] disp_idx = cdhp_disp_idx(ram_ptr_reg, two_line);
    wire logic disp_hit = disp_idx < 7'(`CDHP_DISP_DEPTH);
    wire cdhp_byte_t ram_rd = glyph_sel_reg ? glyph_ram[ram_ptr_reg[5:0]]
                            : (disp_hit ? display_ram[disp_idx] : 8'h00);
    wire cdhp_byte_t rd_byte = reg_select ? ram_rd : {busy_reg, ram_ptr_reg}; // R13 R6
    wire cdhp_byte_t out_next = bus4 ? {phase_low_reg ? rd_byte[3:0] : rd_byte[7:4], 4'h0}
                              : rd_byte; // R5 R16
    wire logic [7:0] oe_next = (xfer_strobe & dir_select) ? (bus4 ? 8'hF0 : 8'hFF) : 8'h00; // R17 R5
    wire logic [6:0] ptr_step_raw = decr ? ram_ptr_reg - 7'h01 : ram_ptr_reg + 7'h01;
    wire logic [6:0] ptr_step = glyph_sel_reg ? {1'b0, ptr_step_raw[5:0]} : ptr_step_raw;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strobe_prev_reg <= 1'b0;
            phase_low_reg <= 1'b0;
            nib_hold_reg <= 4'h0;
            data_out_reg <= 8'h00;
            data_oe_reg <= 8'h00;
        end else begin
            strobe_prev_reg <= xfer_strobe;
            data_out_reg <= out_next;
            data_oe_reg <= oe_next;
            // a control register write with wstrb bit 0 set restarts nibble pairing
            if (ctrl_wr) begin
                phase_low_reg <= 1'b0;
            end else if (strobe_fall && bus4) begin
                phase_low_reg <= ~phase_low_reg; // R16
                nib_hold_reg <= bus_data_in[7:4];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            busy_cnt_reg <= 9'h000;
        end else if (wr_ok) begin
            busy_reg <= 1'b1; // R14
            busy_cnt_reg <= 9'(`CDHP_BUSY_CYC - 1);
        end else if (busy_reg) begin
            if (busy_cnt_reg == 9'h000) begin
                busy_reg <= 1'b0;
            end else begin
                busy_cnt_reg <= busy_cnt_reg - 9'h001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            instruction_reg <= 8'h00;
            ram_ptr_reg <= 7'h00;
            glyph_sel_reg <= 1'b0;
        end else if (instr_wr) begin
            instruction_reg <= wr_byte;
            // only the address-setting codes touch the pointer here
            if (wr_byte[7]) begin
                ram_ptr_reg <= wr_byte[6:0];
                glyph_sel_reg <= 1'b0;
            end else if (wr_byte[6]) begin
                ram_ptr_reg <= {1'b0, wr_byte[5:0]};
                glyph_sel_reg <= 1'b1;
            end
        end else if (data_wr || data_rd) begin
            ram_ptr_reg <= ptr_step; // R15
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < `CDHP_DISP_DEPTH; i++) begin
                display_ram[i] <= 8'h20;
            end
            for (int i = 0; i < `CDHP_GLYPH_DEPTH; i++) begin
                glyph_ram[i] <= 8'h00;
            end
        end else if (data_wr) begin
            if (glyph_sel_reg) begin
                glyph_ram[ram_ptr_reg[5:0]] <= wr_byte; // R8
            end else if (disp_hit) begin
                display_ram[disp_idx] <= wr_byte; // R7
            end
        end
    end

    assign bus_data_out = data_out_reg;
    assign bus_data_oe = data_oe_reg;

    // scan framing
    logic [7:0] div_cnt_reg;
    logic [3:0] row_reg;
    logic [15:0] common_reg;
    logic [39:0] segment_reg;
    logic [39:0] seg_next;
    wire logic row_tick = (div_cnt_reg == 8'(`CDHP_ROW_CYC - 1));
    wire logic [4:0] row_inc = {1'b0, row_reg} + 5'h01;
    wire logic row_live = {1'b0, row_reg} < rows;
    // unscanned commons stay at the non-selection level (0)
    wire logic [15:0] common_next = row_live ? (16'h0001 << row_reg) : 16'h0000; // R11 R12
    wire logic line2 = two_line & row_reg[3];
    wire logic [2:0] glyph_row = row_reg[2:0];

    always_comb begin
        logic [7:0] code;
        logic [6:0] cidx;
        logic [5:0] gaddr;
        code = 8'h00;
        cidx = 7'h00;
        gaddr = 6'h00;
        seg_next = 40'h00_0000_0000;
        for (int c = 0; c < 8; c++) begin
            cidx = cdhp_disp_idx({line2, 3'h0, 3'(c)}, two_line);
            code = display_ram[cidx];
            gaddr = (duty == CDHP_DUTY_11) ? {code[2:1], row_reg} : {code[2:0], glyph_row};
            // codes from 8 up are not built here; their five segments stay 0
            if (code[7:3] == 5'h00) begin
                seg_next[c*5 +: 5] = glyph_ram[gaddr][4:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_cnt_reg <= 8'h00;
            row_reg <= 4'h0;
            common_reg <= 16'h0000;
            segment_reg <= 40'h00_0000_0000;
        end else begin
            div_cnt_reg <= row_tick ? 8'h00 : div_cnt_reg + 8'h01;
            common_reg <= common_next; // R10
            segment_reg <= row_live ? seg_next : 40'h00_0000_0000;
            if (!row_live || (row_tick && row_inc >= rows)) begin
                row_reg <= 4'h0; // R9
            end else if (row_tick) begin
                row_reg <= row_inc[3:0];
            end
        end
    end

    assign common_outputs_low = common_reg[7:0];
    assign common_outputs_high = common_reg[15:8];
    assign segment_output = segment_reg;

    // AXI4-Lite slave
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    wire logic aw_take = s_axi_awvalid & awready_reg;
    wire logic w_take = s_axi_wvalid & wready_reg;
    wire logic wr_fire = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire logic wr_ctrl_hit = awaddr_reg == `CDHP_CTRL_OFS;
    wire logic wr_map_hit = wr_ctrl_hit | (awaddr_reg == `CDHP_STATUS_OFS);
    wire logic [31:0] status_word = {4'h0, row_reg, instruction_reg, 7'h00, glyph_sel_reg,
                                     busy_reg, ram_ptr_reg};
    wire logic ar_ctrl = s_axi_araddr == `CDHP_CTRL_OFS;
    wire logic ar_status = s_axi_araddr == `CDHP_STATUS_OFS;
    wire logic [31:0] rd_word = ar_ctrl ? {28'h000_0000, ctrl_reg}
                              : (ar_status ? status_word : 32'h0000_0000);
    assign ctrl_wr = wr_fire & wr_ctrl_hit & wstrb_reg[0];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            ctrl_reg <= `CDHP_CTRL_RESET;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
                awready_reg <= 1'b0;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                wready_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_map_hit ? 2'h0 : 2'h2;
                if (ctrl_wr) begin
                    ctrl_reg <= wdata_reg[3:0];
                end
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h0000_0000;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= (ar_ctrl | ar_status) ? 2'h0 : 2'h2;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // checks
    nonsel_eleven_a: assert property ( // R12
        duty == CDHP_DUTY_11 && $past(duty == CDHP_DUTY_11) |-> common_reg[15:11] == 5'h00)
        else $error("commons 12-16 selected at 1/11");
    nonsel_eight_a: assert property ( // R11
        duty == CDHP_DUTY_8 && $past(duty == CDHP_DUTY_8) |-> common_reg[15:8] == 8'h00)
        else $error("upper commons selected at 1/8");
    common_onehot_a: assert property ($onehot0(common_reg)) // R10
        else $error("more than one common selected");
    row_bound_a: assert property ($stable(rows) |-> {1'b0, row_reg} < rows) // R9
        else $error("scan row past duty");
    status_read_a: assert property ( // R13
        xfer_strobe && dir_select && !reg_select && !bus4
        |=> bus_data_out == {$past(busy_reg), $past(ram_ptr_reg)} && bus_data_oe == 8'hFF)
        else $error("status read wrong");
    low_lines_off_a: assert property ($past(bus4) |-> bus_data_oe[3:0] == 4'h0) // R5
        else $error("low lines driven in 4-bit mode");
    oe_dir_a: assert property (bus_data_oe != 8'h00 |-> $past(dir_select && xfer_strobe)) // R2
        else $error("data lines driven outside a read");
    busy_refuse_a: assert property ( // R14
        strobe_fall && !reg_select && !dir_select && busy_reg |=> $stable(instruction_reg))
        else $error("instruction taken while busy");
    busy_len_a: assert property ($rose(busy_reg) |-> ##249 busy_reg ##1 !busy_reg) // R14 R6
        else $error("busy length wrong");
    ptr_step_a: assert property ( // R15
        data_wr && !decr && !glyph_sel_reg |=> ram_ptr_reg == $past(ram_ptr_reg) + 7'h01)
        else $error("pointer did not step");
    nibble_pair_a: assert property ( // R16
        bus4 && !ctrl_wr && strobe_fall && !phase_low_reg |=> phase_low_reg ##0 !$changed(instruction_reg))
        else $error("high nibble completed a byte");
endmodule : cdhp_top
`default_nettype wire

// ==== test/cdhp_host_model.sv ====
// host microprocessor model for the character display host port
// assumes the bench calls its tasks and sets four_bit before use
`timescale 1ns/1ns
`default_nettype none

module cdhp_host_model (
    input wire logic core_clk,
    input wire logic [7:0] bus_data_out,
    input wire logic [7:0] bus_data_oe,
    output logic reg_select,
    output logic dir_select,
    output logic xfer_strobe,
    output logic [7:0] bus_data_in
);
    logic four_bit = 1'b0;
    logic [7:0] last_view = 8'h00;
    logic [7:0] last_oe = 8'h00;

    initial begin
        reg_select = 1'b0;
        dir_select = 1'b0;
        xfer_strobe = 1'b0;
        bus_data_in = 8'h00;
    end

    // selects settle with the strobe rise and hold through the taking edge
    task automatic xfer(input logic rs, input logic rd, input logic [7:0] d, output logic [7:0] q);
        q = 8'h00;
        @(posedge core_clk);
        reg_select <= rs;
        dir_select <= rd;
        bus_data_in <= d;
        xfer_strobe <= 1'b1;
        @(posedge core_clk);
        if (rd) begin
            @(posedge core_clk);
            // undriven lines seen as the inverse of the last view
            q = (bus_data_out & bus_data_oe) | (~last_view & ~bus_data_oe);
            last_view = q;
            last_oe = bus_data_oe;
        end
        xfer_strobe <= 1'b0;
        @(posedge core_clk);
        bus_data_in <= ~d;
    endtask : xfer

    task automatic wr_byte(input logic rs, input logic [7:0] b);
        logic [7:0] q;
        if (four_bit) begin
            xfer(rs, 1'b0, {b[7:4], 4'($urandom)}, q);
            xfer(rs, 1'b0, {b[3:0], 4'($urandom)}, q);
        end else begin
            xfer(rs, 1'b0, b, q);
        end
    endtask : wr_byte

    task automatic rd_byte(input logic rs, output logic [7:0] b);
        logic [7:0] hi;
        logic [7:0] lo;
        if (four_bit) begin
            xfer(rs, 1'b1, 8'h00, hi);
            xfer(rs, 1'b1, 8'h00, lo);
            b = {hi[7:4], lo[7:4]};
        end else begin
            xfer(rs, 1'b1, 8'h00, b);
        end
    endtask : rd_byte

    // poll busy before the next write; bounded so a stuck flag ends
    task automatic wait_idle();
        logic [7:0] s;
        int polls;
        polls = 0;
        do begin
            rd_byte(1'b0, s);
            polls++;
        end while (s[7] === 1'b1 && polls < 200);
    endtask : wait_idle
endmodule : cdhp_host_model

`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for cdhp_top: host port, scan framing, AXI4-Lite
// assumes cdhp_host_model as the host and the bench as AXI master
`include "cdhp_map.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import cdhp_pkg::*;
();
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_select, dir_select, xfer_strobe;
    logic [7:0] bus_data_in, bus_data_out, bus_data_oe;
    logic [7:0] common_outputs_low, common_outputs_high;
    logic [39:0] segment_output;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] w;
    logic [7:0] b, a, d;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;

    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    cdhp_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_select(reg_select),
        .dir_select(dir_select), .xfer_strobe(xfer_strobe), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
        .common_outputs_low(common_outputs_low), .common_outputs_high(common_outputs_high),
        .segment_output(segment_output), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    cdhp_host_model host_u (.core_clk(core_clk), .bus_data_out(bus_data_out),
        .bus_data_oe(bus_data_oe), .reg_select(reg_select), .dir_select(dir_select),
        .xfer_strobe(xfer_strobe), .bus_data_in(bus_data_in));

    function automatic logic [7:0] st_exp(input logic busy, input logic [6:0] ptr);
        return {busy, ptr};
    endfunction : st_exp

    // unscanned commons must never show a selection pulse
    function automatic logic [31:0] scan_mask(input cdhp_duty_t dt);
        return (dt == CDHP_DUTY_16) ? 32'hFFFF : (dt == CDHP_DUTY_11) ? 32'h07FF : 32'h00FF;
    endfunction : scan_mask

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= ad;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= dt;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        dt = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic cmd(input logic [7:0] v);
        host_u.wr_byte(1'b0, v);
        host_u.wait_idle();
    endtask : cmd

    task automatic put(input logic [7:0] v);
        host_u.wr_byte(1'b1, v);
        host_u.wait_idle();
    endtask : put

    task automatic scan_check(input cdhp_duty_t dt);
        logic [15:0] seen;
        logic [4:0] row0;
        int bad;
        seen = 16'h0;
        row0 = 5'h0;
        bad = 0;
        axi_wr(`CDHP_CTRL_OFS, {29'h0, 2'(dt), 1'b0}, rsp);
        repeat (4100) begin
            @(posedge core_clk);
            seen |= {common_outputs_high, common_outputs_low};
            if ($countones({common_outputs_high, common_outputs_low}) > 1) bad++;
            if (common_outputs_low[0] === 1'b1) row0 = segment_output[4:0];
        end
        chk_word("commons seen", scan_mask(dt), {16'h0, seen});
        chk_word("common overlap", 32'h0, 32'(bad));
        chk_byte("glyph row segments", 8'h15, {3'h0, row0});
        $display("test scan duty %0d done", dt);
    endtask : scan_check

    initial begin
        repeat (50000) @(posedge core_clk);
        n_fail++;
        $display("mismatch watchdog expected finish seen timeout");
        give_verdict();
    end

    initial begin
        void'($urandom(32'h7831));
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        axi_rd(`CDHP_CTRL_OFS, w, rsp);
        chk_word("ctrl reset", 32'h0, w);
        axi_rd(8'h08, w, rsp);
        chk_word("unmapped read resp", 32'h2, {30'h0, rsp});
        axi_wr(8'h0C, 32'hFFFF_FFFF, rsp);
        chk_word("unmapped write resp", 32'h2, {30'h0, rsp});
        axi_wr(`CDHP_STATUS_OFS, 32'hFFFF_FFFF, rsp);
        axi_rd(`CDHP_STATUS_OFS, w, rsp);
        chk_word("status read only", 32'h0, {24'h0, w[7:0]});
        $display("test registers done");
        host_u.wr_byte(1'b0, 8'h85);
        t0 = cyc;
        host_u.rd_byte(1'b0, b);
        chk_byte("status busy", st_exp(1'b1, 7'h05), b);
        chk_byte("read enables", 8'hFF, host_u.last_oe);
        host_u.wait_idle();
        chk_word("busy span", 32'h1, 32'((cyc - t0) >= 250 && (cyc - t0) <= 264));
        host_u.wr_byte(1'b1, 8'h41);
        host_u.wr_byte(1'b1, 8'h42);
        // instruction while busy must be dropped as well
        host_u.wr_byte(1'b0, 8'h81);
        host_u.wait_idle();
        host_u.rd_byte(1'b0, b);
        chk_byte("pointer after dropped write", st_exp(1'b0, 7'h06), b);
        cmd(8'h85);
        host_u.rd_byte(1'b1, b);
        chk_byte("data read", 8'h41, b);
        host_u.rd_byte(1'b1, b);
        chk_byte("dropped byte absent", 8'h20, b);
        host_u.rd_byte(1'b0, b);
        chk_byte("pointer after reads", st_exp(1'b0, 7'h07), b);
        $display("test busy and pointer done");
        cmd(8'hCF);
        put(8'h5A);
        put(8'h33);
        cmd(8'hCF);
        host_u.rd_byte(1'b1, b);
        chk_byte("last display byte", 8'h5A, b);
        host_u.rd_byte(1'b1, b);
        chk_byte("beyond display ram", 8'h00, b);
        for (int i = 0; i < 5; i++) begin
            a = 8'($urandom_range(79, 1));
            d = 8'($urandom);
            cmd(8'h80 | a);
            put(d);
            cmd(8'h80 | a);
            host_u.rd_byte(1'b1, b);
            chk_byte("display ram random", d, b);
        end
        $display("test display ram done");
        cmd(8'h40);
        put(8'h15);
        cmd(8'h40);
        host_u.rd_byte(1'b1, b);
        chk_byte("glyph ram", 8'h15, b);
        host_u.rd_byte(1'b0, b);
        chk_byte("glyph pointer", st_exp(1'b0, 7'h01), b);
        cmd(8'h80);
        put(8'h00);
        axi_rd(`CDHP_STATUS_OFS, w, rsp);
        chk_word("status word", 32'h0080_0001, {8'h00, w[23:0]});
        $display("test glyph ram done");
        scan_check(CDHP_DUTY_8);
        scan_check(CDHP_DUTY_11);
        scan_check(CDHP_DUTY_16);
        axi_wr(`CDHP_CTRL_OFS, 32'h1, rsp);
        host_u.four_bit = 1'b1;
        cmd(8'h90);
        put(8'hC3);
        cmd(8'h90);
        host_u.rd_byte(1'b1, b);
        chk_byte("nibble data", 8'hC3, b);
        chk_byte("nibble enables", 8'hF0, host_u.last_oe);
        host_u.rd_byte(1'b0, b);
        chk_byte("nibble status", st_exp(1'b0, 7'h11), b);
        axi_wr(`CDHP_CTRL_OFS, 32'h9, rsp);
        cmd(8'h8A);
        put(8'h77);
        host_u.rd_byte(1'b0, b);
        chk_byte("pointer decrement", st_exp(1'b0, 7'h09), b);
        $display("test four bit done");
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
